// ==== verilog/etm_tx_overhead.sv ====
// Overview of operation
// - Sixteen writable trace bytes are sent one per frame in the trail-trace octet over a repeating sixteen-frame cycle.
// - Trace byte fourteen is fetched during the fifteenth frame and sent in the frame after it.
// - Trace byte fifteen is fetched during the sixteenth frame and sent in the frame after it.
// - Every trace byte n is fetched in frame n+1 of the cycle and sent in the following frame.
// - The first framing octet leaves XORed with the first framing mask register.
// - The second framing octet leaves XORed with the second framing mask register.
// - The error-monitor octet leaves XORed with the error-monitor mask register.
// - All masks reset to zero and a zero mask leaves its octet untouched.
`timescale 1ns/10ps

module etm_tx_overhead #(
	parameter int unsigned ADDR_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_sof,
	input wire logic [2:0] in_kind,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output logic out_sof,
	output logic [2:0] out_kind
);

	generate
		if (ADDR_W < 10)
		begin : g_addr_check
			$error("etm_tx_overhead: ADDR_W must be at least 10");
		end
	endgenerate

	typedef struct packed {
		logic [etm_pkg::ETM_TRACE_LEN-1:0][etm_pkg::ETM_OCT_W-1:0] trace;
		logic [7:0] mask_fa1;
		logic [7:0] mask_fa2;
		logic [7:0] mask_em;
		logic [etm_pkg::ETM_POS_W-1:0] pos;
		logic [7:0] fetch;
		logic [7:0] send;
		logic out_v;
		logic [7:0] out_d;
		logic out_sof;
		logic [2:0] out_kind;
		logic skid_v;
		logic [7:0] skid_d;
		logic skid_sof;
		logic [2:0] skid_kind;
		logic in_rdy;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} etm_state_s;

	etm_state_s s_r;
	etm_state_s s_nxt;
	logic acc;
	logic acc_sof;
	logic load_out;
	logic [7:0] proc_d;
	logic [7:0] idx;

	function automatic logic is_trace(input logic [7:0] i);
		is_trace = (i >= etm_pkg::ETM_IDX_TRACE_BASE) &&
			(i <= etm_pkg::ETM_IDX_TRACE_FIFTEEN);
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		is_mapped = (a[1:0] == 2'h0) && ((a >> 10) == '0) &&
			(is_trace(i) || (i == etm_pkg::ETM_IDX_FA1_MASK) ||
			(i == etm_pkg::ETM_IDX_FA2_MASK) ||
			(i == etm_pkg::ETM_IDX_EM_MASK) ||
			(i == etm_pkg::ETM_IDX_STATUS));
	endfunction

	always_comb
	begin
		s_nxt = s_r;
		idx = paddr[9:2];
		acc = s_r.in_rdy && in_valid;
		acc_sof = acc && in_sof;
		load_out = 1'b0;
		// frame boundary: what was fetched last frame goes out now
		if (acc_sof)
		begin
			s_nxt.pos = s_r.pos + 1'b1;
			s_nxt.send = s_r.fetch;
			s_nxt.fetch = s_r.trace[s_nxt.pos];
		end
		// masks are applied as they stand when the octet passes
		proc_d = in_data;
		case (in_kind)
			etm_pkg::ETM_K_FA1: proc_d = in_data ^ s_r.mask_fa1;
			etm_pkg::ETM_K_FA2: proc_d = in_data ^ s_r.mask_fa2;
			etm_pkg::ETM_K_EM: proc_d = in_data ^ s_r.mask_em;
			etm_pkg::ETM_K_TR: proc_d = s_nxt.send;
			default: proc_d = in_data;
		endcase
		// two-entry skid: output stage plus one spare word
		if (!s_r.out_v || out_ready)
		begin
			if (s_r.skid_v)
			begin
				s_nxt.out_v = 1'b1;
				s_nxt.out_d = s_r.skid_d;
				s_nxt.out_sof = s_r.skid_sof;
				s_nxt.out_kind = s_r.skid_kind;
				s_nxt.skid_v = 1'b0;
			end
			else
			begin
				s_nxt.out_v = acc;
				load_out = acc;
				if (acc)
				begin
					s_nxt.out_d = proc_d;
					s_nxt.out_sof = in_sof;
					s_nxt.out_kind = in_kind;
				end
			end
		end
		else if (acc)
		begin
			s_nxt.skid_v = 1'b1;
			s_nxt.skid_d = proc_d;
			s_nxt.skid_sof = in_sof;
			s_nxt.skid_kind = in_kind;
		end
		// ready is registered, so the spare word absorbs its lag
		s_nxt.in_rdy = !s_nxt.skid_v;
		// apb: answer in the first access cycle
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		if (psel && !penable)
		begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = !is_mapped(paddr);
			s_nxt.prdata = etm_pkg::ETM_RST_WORD;
			if (!pwrite && is_mapped(paddr))
			begin
				if (is_trace(idx))
					s_nxt.prdata[7:0] = s_r.trace[4'(idx -
						etm_pkg::ETM_IDX_TRACE_BASE)];
				else if (idx == etm_pkg::ETM_IDX_FA1_MASK)
					s_nxt.prdata[7:0] = s_r.mask_fa1;
				else if (idx == etm_pkg::ETM_IDX_FA2_MASK)
					s_nxt.prdata[7:0] = s_r.mask_fa2;
				else if (idx == etm_pkg::ETM_IDX_EM_MASK)
					s_nxt.prdata[7:0] = s_r.mask_em;
				else
					s_nxt.prdata[3:0] = s_r.pos;
			end
		end
		if (psel && penable && s_r.pready && pwrite && !s_r.pslverr)
		begin
			if (is_trace(idx))
				s_nxt.trace[4'(idx - etm_pkg::ETM_IDX_TRACE_BASE)] =
					pwdata[7:0];
			else if (idx == etm_pkg::ETM_IDX_FA1_MASK)
				s_nxt.mask_fa1 = pwdata[7:0];
			else if (idx == etm_pkg::ETM_IDX_FA2_MASK)
				s_nxt.mask_fa2 = pwdata[7:0];
			else if (idx == etm_pkg::ETM_IDX_EM_MASK)
				s_nxt.mask_em = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.mask_fa1 <= etm_pkg::ETM_RST_OCTET;
			s_r.mask_fa2 <= etm_pkg::ETM_RST_OCTET;
			s_r.mask_em <= etm_pkg::ETM_RST_OCTET;
			s_r.pos <= etm_pkg::ETM_RST_POS;
			s_r.in_rdy <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign in_ready = s_r.in_rdy;
	assign out_valid = s_r.out_v;
	assign out_data = s_r.out_d;
	assign out_sof = s_r.out_sof;
	assign out_kind = s_r.out_kind;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence frame_start_s;
		acc_sof;
	endsequence

	sequence enter_fifteenth_s;
		acc_sof && (s_nxt.pos == etm_pkg::ETM_POS_FIFTEENTH);
	endsequence

	sequence enter_sixteenth_s;
		acc_sof && (s_nxt.pos == etm_pkg::ETM_POS_SIXTEENTH);
	endsequence

	trace_tr_out_a: assert property (
		load_out && (in_kind == etm_pkg::ETM_K_TR) && !in_sof
		|=> out_data == $past(s_r.send))
		else $error("trail-trace octet not the trace byte due");

	fetch_fourteen_a: assert property (
		enter_fifteenth_s |=> s_r.fetch ==
			$past(s_r.trace[etm_pkg::ETM_TRACE_FOURTEEN]))
		else $error("byte fourteen not fetched in fifteenth frame");

	// the fetch of the fifteenth frame goes out in the sixteenth
	send_fourteen_a: assert property (
		enter_sixteenth_s |=> s_r.send == $past(s_r.fetch))
		else $error("byte fourteen not sent in the next frame");

	fetch_fifteen_a: assert property (
		enter_sixteenth_s |=> s_r.fetch ==
			$past(s_r.trace[etm_pkg::ETM_TRACE_FIFTEEN]))
		else $error("byte fifteen not fetched in sixteenth frame");

	send_next_frame_a: assert property (
		frame_start_s |=> (s_r.send == $past(s_r.fetch)) &&
			(s_r.fetch == $past(s_r.trace[s_nxt.pos])))
		else $error("fetched byte not carried into next frame");

	fa1_mask_a: assert property (
		load_out && (in_kind == etm_pkg::ETM_K_FA1)
		|=> out_data == ($past(in_data) ^ $past(s_r.mask_fa1)))
		else $error("first framing octet not masked");

	fa2_mask_a: assert property (
		load_out && (in_kind == etm_pkg::ETM_K_FA2)
		|=> out_data == ($past(in_data) ^ $past(s_r.mask_fa2)))
		else $error("second framing octet not masked");

	em_mask_a: assert property (
		load_out && (in_kind == etm_pkg::ETM_K_EM)
		|=> out_data == ($past(in_data) ^ $past(s_r.mask_em)))
		else $error("error-monitor octet not masked");

	zero_mask_a: assert property (
		load_out && (in_kind == etm_pkg::ETM_K_FA1) &&
		(s_r.mask_fa1 == etm_pkg::ETM_RST_OCTET)
		|=> out_data == $past(in_data))
		else $error("zero mask altered the octet");

	frame_pos_a: assert property (
		(acc_sof |=> s_r.pos == 4'($past(s_r.pos) + 1'b1)) and
		(!acc_sof |=> $stable(s_r.pos)))
		else $error("frame position did not step once per frame");

	buffer_hold_a: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("stalled output word changed");

	apb_answer_a: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one access cycle");

endmodule // etm_tx_overhead

// ==== verilog/etm_pkg.sv ====
package etm_pkg;

	localparam int unsigned ETM_DATA_W = 32;
	localparam int unsigned ETM_OCT_W = 8;
	localparam int unsigned ETM_TRACE_LEN = 16;
	localparam int unsigned ETM_POS_W = 4;
	localparam int unsigned ETM_KIND_W = 3;
	localparam int unsigned ETM_IDX_LSB = 2;
	localparam int unsigned ETM_IDX_W = 8;

	// register indexes; byte address is four times the index
	localparam logic [7:0] ETM_IDX_TRACE_BASE = 8'h38;
	localparam logic [7:0] ETM_IDX_TRACE_FOURTEEN = 8'h46;
	localparam logic [7:0] ETM_IDX_TRACE_FIFTEEN = 8'h47;
	localparam logic [7:0] ETM_IDX_FA1_MASK = 8'h48;
	localparam logic [7:0] ETM_IDX_FA2_MASK = 8'h49;
	localparam logic [7:0] ETM_IDX_EM_MASK = 8'h4A;
	localparam logic [7:0] ETM_IDX_STATUS = 8'h4B;

	localparam logic [7:0] ETM_RST_OCTET = 8'h00;
	localparam logic [31:0] ETM_RST_WORD = 32'h0000_0000;
	// first frame after reset lands on position zero
	localparam logic [3:0] ETM_RST_POS = 4'hF;
	localparam logic [3:0] ETM_POS_FIFTEENTH = 4'hE;
	localparam logic [3:0] ETM_POS_SIXTEENTH = 4'hF;
	localparam logic [3:0] ETM_TRACE_FOURTEEN = 4'hE;
	localparam logic [3:0] ETM_TRACE_FIFTEEN = 4'hF;

	// octet kind codes on the stream
	localparam logic [2:0] ETM_K_PAYLOAD = 3'h0;
	localparam logic [2:0] ETM_K_FA1 = 3'h1;
	localparam logic [2:0] ETM_K_FA2 = 3'h2;
	localparam logic [2:0] ETM_K_EM = 3'h3;
	localparam logic [2:0] ETM_K_TR = 3'h4;

endpackage

// ==== tb/etm_line_sink.sv ====
`timescale 1ns/10ps
module etm_line_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [7:0] out_data,
	input wire logic out_sof,
	input wire logic [2:0] out_kind
);
	logic [1:0] cnt;
	logic [11:0] got[$];
	// slow line takes one octet in four so the buffer backs up
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 2'h0;
			out_ready <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 2'h1;
			out_ready <= !slow || cnt == 2'h3;
			if (out_valid && out_ready)
				got.push_back({out_sof, out_kind, out_data});
		end
	end
endmodule // etm_line_sink

// ==== tb/e3_g832_tx_trace_and_error_mask_bench.sv ====
`timescale 1ns/10ps
module e3_g832_tx_trace_and_error_mask_bench;
	logic pclk, presetn, psel, penable, pwrite, in_valid, in_sof, slow;
	logic pready, pslverr, in_ready, out_valid, out_ready, out_sof, err;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] in_data, out_data;
	logic [2:0] in_kind, out_kind;
	logic [7:0] trace[16];
	logic [11:0] exp_q[$];
	int failures, n_tests, cycles, fno;
	etm_tx_overhead #(.ADDR_W(10)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.in_sof(in_sof), .in_kind(in_kind), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_sof(out_sof),
		.out_kind(out_kind));
	etm_line_sink u_sink (.pclk(pclk), .presetn(presetn), .slow(slow),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
		.out_sof(out_sof), .out_kind(out_kind));
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want)
		begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// ready, read data and error are all taken at one rising edge
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// caller sits just after an edge; valid is held between octets
	task automatic put(input logic [2:0] k, input logic [7:0] d,
		input logic s, input logic [7:0] x);
		in_valid <= 1'b1;
		in_kind <= k;
		in_data <= d;
		in_sof <= s;
		// the octet is taken at the rising edge that sees ready high
		do
			@(posedge pclk);
		while (in_ready !== 1'b1);
		exp_q.push_back({s, k, x});
	endtask
	task automatic frames(input int n, input logic [7:0] m1, m2, m3);
		@(posedge pclk);
		repeat (n)
		begin
			put(3'h1, 8'hF6, 1'b1, 8'hF6 ^ m1);
			put(3'h2, 8'h28, 1'b0, 8'h28 ^ m2);
			put(3'h3, 8'h55, 1'b0, 8'h55 ^ m3);
			put(3'h4, 8'hC3, 1'b0,
				fno == 0 ? 8'h00 : trace[(fno + 15) % 16]);
			put(3'h0, 8'h9A, 1'b0, 8'h9A);
			fno++;
		end
		in_valid <= 1'b0;
		while (u_sink.got.size() < exp_q.size())
			@(posedge pclk);
		foreach (exp_q[i])
			chk({20'h0, u_sink.got[i]}, {20'h0, exp_q[i]});
		exp_q.delete();
		u_sink.got.delete();
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, in_valid, in_sof, slow} = 7'h00;
		{paddr, pwdata, in_data, in_kind} = 53'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 8'h46; i <= 8'h4A; i++)
		begin
			apb(1'b0, i[7:0], 32'h0);
			chk(rd, etm_pkg::ETM_RST_WORD);
		end
		$display("test reset values done");
		for (int i = 0; i < 16; i++)
		begin
			trace[i] = 8'h41 + i[7:0];
			apb(1'b1, etm_pkg::ETM_IDX_TRACE_BASE + i[7:0],
				{24'h0, trace[i]});
		end
		apb(1'b1, etm_pkg::ETM_IDX_FA1_MASK, 32'hA5);
		apb(1'b1, etm_pkg::ETM_IDX_FA2_MASK, 32'h3C);
		apb(1'b1, etm_pkg::ETM_IDX_EM_MASK, 32'h0F);
		apb(1'b0, etm_pkg::ETM_IDX_TRACE_FOURTEEN, 32'h0);
		chk(rd, {24'h0, trace[14]});
		apb(1'b0, etm_pkg::ETM_IDX_EM_MASK, 32'h0);
		chk(rd, 32'h0F);
		apb(1'b0, 8'hFF, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test registers done");
		slow <= 1'b1;
		frames(17, 8'hA5, 8'h3C, 8'h0F);
		apb(1'b0, etm_pkg::ETM_IDX_STATUS, 32'h0);
		chk(rd, 32'h0);
		$display("test trace cycle with masks done");
		slow <= 1'b0;
		apb(1'b1, etm_pkg::ETM_IDX_FA1_MASK, 32'h0);
		apb(1'b1, etm_pkg::ETM_IDX_FA2_MASK, 32'h0);
		apb(1'b1, etm_pkg::ETM_IDX_EM_MASK, 32'h0);
		frames(2, 8'h00, 8'h00, 8'h00);
		$display("test zero masks done");
		close_out();
	end
endmodule // e3_g832_tx_trace_and_error_mask_bench
